// ---- hw/dshci_pkg.sv ----
// Constants and types shared by the disk synchronizer host interface
package dshci_pkg;

  // ****************************************************************
  // Word layout: bit 0 is the most significant of the 36-bit word
  // ****************************************************************
  localparam int DSHCI_WORD_W      = 36;
  localparam int DSHCI_NUM_FLAGS   = 10;
  // Initiation word fields
  localparam int INIT_DISK_LO      = 0;
  localparam int INIT_DISK_HI      = 1;
  localparam int INIT_TRACK_HUND   = 2;
  localparam int INIT_TRACK_LO     = 3;
  localparam int INIT_TRACK_HI     = 10;
  localparam int INIT_SEG_LO       = 11;
  localparam int INIT_SEG_HI       = 17;
  localparam int INIT_BIAS_LO      = 18;
  localparam int INIT_BIAS_HI      = 23;
  localparam int INIT_DPE_DIS      = 24;
  localparam int INIT_CPE_DIS      = 25;
  localparam int INIT_WRITE        = 26;
  localparam int INIT_CWA_LO       = 27;
  localparam int INIT_CWA_HI       = 34;
  localparam int INIT_EVEN_PAR     = 35;
  // Word-in readback fields
  localparam int WIN_BIAS_LO       = 18;
  localparam int WIN_BIAS_HI       = 23;
  localparam int WIN_SCSEL_LO      = 26;
  localparam int WIN_SCSEL_HI      = 27;
  localparam int WIN_SECT_LO       = 28;
  localparam int WIN_SECT_HI       = 35;
  // Conditions-out fields
  localparam int COUT_SCSEL_LO     = 18;
  localparam int COUT_SCSEL_HI     = 19;
  localparam int COUT_FLAG_LO      = 20;
  localparam int COUT_CW_STORE     = 30;
  localparam int COUT_STOP         = 31;
  localparam int COUT_DONE_CLR     = 32;
  localparam int COUT_PI_LO        = 33;
  localparam int COUT_PI_HI        = 35;
  // Conditions-in fields
  localparam int CIN_MAINT         = 5;
  localparam int CIN_PROT_MODE     = 6;
  localparam int CIN_BOUNDS_LO     = 7;
  localparam int CIN_BOUNDS_HI     = 17;
  localparam int CIN_XFER          = 18;
  localparam int CIN_SRCH_ERR      = 19;
  localparam int CIN_FLAG_LO       = 20;
  localparam int CIN_CW_COMP       = 30;
  localparam int CIN_BUSY          = 31;
  localparam int CIN_DONE          = 32;
  localparam int CIN_PI_LO         = 33;
  localparam int CIN_PI_HI         = 35;
  // Error flag indices (flag n sits at word bit 20 + n)
  localparam int FLG_DUP_UNIT      = 0;
  localparam int FLG_TRACK         = 1;
  localparam int FLG_DPE           = 4;
  localparam int FLG_CPE           = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [0:35] DSHCI_WORD_RST = 36'h000000000;
  localparam logic [0:1]  SCSEL_RST      = 2'h0;
  localparam logic [0:2]  PI_LEVEL_RST   = 3'h0;
  localparam logic [0:7]  CWA_RST        = 8'h00;

  // ****************************************************************
  // State machines
  // ****************************************************************
  typedef enum logic [2:0] {
    COUT_IDLE = 3'b001,
    COUT_CLR  = 3'b010,
    COUT_SET  = 3'b100
  } dshci_cout_e;

  typedef enum logic [3:0] {
    CHN_IDLE = 4'b0001,
    CHN_REQ  = 4'b0010,
    CHN_SEND = 4'b0100,
    CHN_RUN  = 4'b1000
  } dshci_chan_e;

endpackage

// ---- hw/dshci_flag_if.sv ----
// Set, clear and state of one sticky status flag
`timescale 1ns/1ps
interface dshci_flag_if;
  logic set;
  logic clr;
  logic q;
  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

// ---- hw/dshci_sticky_flag.sv ----
// One sticky flag where a set in the clear cycle wins
`timescale 1ns/1ps
module dshci_sticky_flag
  import dshci_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  // Flag
  dshci_flag_if.owner     flag
);

  logic q_reg;
  logic q_next;

  // Set wins so that an event in the clear cycle is kept
  assign q_next = flag.set | (q_reg & ~flag.clr);
  assign flag.q = q_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule

// ---- hw/dshci_top.sv ----
// Host command and status interface of the disk synchronizer
`timescale 1ns/1ps

module dshci_top
  import dshci_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // Processor I/O transfers
  input  wire logic        word_out_transfer_in,
  input  wire logic [0:35] word_out_data_in,
  input  wire logic        conditions_out_transfer_in,
  input  wire logic [18:35] conditions_out_data_in,
  input  wire logic        word_in_transfer_in,
  input  wire logic        conditions_in_transfer_in,
  output logic      [0:35] read_data_out,
  output logic             read_valid_out,
  output logic             interrupt_request_out,
  output logic      [0:2]  interrupt_priority_level_out,
  // Data channel
  output logic             chan_request_out,
  input  wire logic        chan_grant_in,
  input  wire logic        chan_active_in,
  output logic      [0:8]  chan_cw_addr_out,
  output logic             chan_cw_addr_valid_out,
  output logic             chan_cw_store_out,
  input  wire logic        chan_cw_store_done_in,
  output logic             chan_even_parity_out,
  input  wire logic        chan_cw_cycle_in,
  // Synchronizer core
  output logic      [0:1]  disk_unit_out,
  output logic             track_upper_out,
  output logic      [0:7]  track_bcd_out,
  output logic      [0:6]  segment_bcd_out,
  output logic      [0:5]  parity_bias_out,
  output logic             disk_parity_stop_disable_out,
  output logic             channel_parity_stop_disable_out,
  output logic             write_mode_out,
  output logic             busy_out,
  output logic             start_search_out,
  output logic             terminate_out,
  output logic      [0:1]  sector_unit_select_out,
  input  wire logic [0:7]  sector_count_in,
  input  wire logic        transfer_in_progress_in,
  input  wire logic        search_error_in,
  input  wire logic        operation_end_in,
  input  wire logic [0:9]  error_event_in,
  // Panel switches (asynchronous pins)
  input  wire logic        maintenance_area_only_in,
  input  wire logic        protect_compare_mode_in,
  input  wire logic [0:10] bounds_switch_value_in
);

  // ****************************************************************
  // Switch synchronisers
  // ****************************************************************
  logic [0:12] sw_meta_reg;
  logic [0:12] sw_sync_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      sw_meta_reg <= 13'h0000;
      sw_sync_reg <= 13'h0000;
    end else begin
      sw_meta_reg <= {maintenance_area_only_in, protect_compare_mode_in,
                      bounds_switch_value_in};
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // ****************************************************************
  // Initiation word acceptance
  // ****************************************************************
  logic [0:35] init_reg;
  logic        busy_reg;
  logic        busy_next;
  logic        init_accept;
  logic        track_bad;
  logic        cout_stop;

  assign init_accept = word_out_transfer_in & ~busy_reg;

  // Non-BCD track digits raise the track select error at load time
  assign track_bad =
    (word_out_data_in[INIT_TRACK_LO:INIT_TRACK_LO+3] > 4'h9) |
    (word_out_data_in[INIT_TRACK_LO+4:INIT_TRACK_HI] > 4'h9);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      init_reg <= DSHCI_WORD_RST;
    end else if (init_accept) begin
      init_reg <= word_out_data_in;
    end
  end

  assign busy_next = init_accept |
                     (busy_reg & ~cout_stop & ~operation_end_in);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // ****************************************************************
  // Conditions-out sequencing: clear pulse, then set pulse
  // ****************************************************************
  dshci_cout_e cout_state_reg;
  dshci_cout_e cout_state_next;
  logic [18:35] cout_data_reg;
  logic        cout_clr;
  logic        cout_set;

  always_comb begin
    cout_state_next = cout_state_reg;
    unique case (cout_state_reg)
      COUT_IDLE: begin
        if (conditions_out_transfer_in) begin
          cout_state_next = COUT_CLR;
        end
      end
      COUT_CLR: cout_state_next = COUT_SET;
      COUT_SET: cout_state_next = COUT_IDLE;
    endcase
  end

  assign cout_clr = (cout_state_reg == COUT_CLR);
  assign cout_set = (cout_state_reg == COUT_SET);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cout_state_reg <= COUT_IDLE;
      cout_data_reg  <= 18'h00000;
    end else begin
      cout_state_reg <= cout_state_next;
      if (conditions_out_transfer_in && cout_state_reg == COUT_IDLE) begin
        cout_data_reg <= conditions_out_data_in;
      end
    end
  end

  assign cout_stop = cout_set & cout_data_reg[COUT_STOP];

  // ****************************************************************
  // Control registers loaded by conditions-out
  // ****************************************************************
  logic [0:1] scsel_reg;
  logic [0:2] pi_level_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || cout_clr) begin
      scsel_reg    <= SCSEL_RST;
      pi_level_reg <= PI_LEVEL_RST;
    end else if (cout_set) begin
      scsel_reg    <= cout_data_reg[COUT_SCSEL_LO:COUT_SCSEL_HI];
      pi_level_reg <= cout_data_reg[COUT_PI_LO:COUT_PI_HI];
    end
  end

  // ****************************************************************
  // Sticky error flags (word bits 20-29)
  // ****************************************************************
  logic [0:9] flag_q;
  logic [0:9] flag_set;

  always_comb begin
    flag_set = error_event_in;
    flag_set[FLG_TRACK] = error_event_in[FLG_TRACK] |
                          (init_accept & track_bad);
  end

  genvar gi;
  generate
    for (gi = 0; gi < DSHCI_NUM_FLAGS; gi++) begin : g_flag
      dshci_flag_if flag_bus ();
      // Each set bit clears its flag
      assign flag_bus.set = flag_set[gi];
      assign flag_bus.clr = cout_set & cout_data_reg[COUT_FLAG_LO + gi];
      assign flag_q[gi]   = flag_bus.q;
      dshci_sticky_flag u_flag (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .flag       (flag_bus)
      );
    end
  endgenerate

  // ****************************************************************
  // Stop decisions, search error, done
  // ****************************************************************
  logic stop_event;
  logic srch_err_reg;
  logic done_reg;
  logic done_seen;
  logic cw_comp_reg;

  logic [0:9] stop_mask;

  // Parity stops may be disabled
  // Masking by index keeps other errors stopping when they coincide
  always_comb begin
    stop_mask          = 10'h3FF;
    stop_mask[FLG_DPE] = ~init_reg[INIT_DPE_DIS];
    stop_mask[FLG_CPE] = ~init_reg[INIT_CPE_DIS];
    stop_event         = (|(flag_set & stop_mask)) | search_error_in;
  end

  // Search error clears only when a new search is started
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      srch_err_reg <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      srch_err_reg <= search_error_in | (srch_err_reg & ~init_accept);
      // Done cleared by bit 32, set wins
      done_reg <= operation_end_in | (busy_reg & stop_event) |
                  (done_reg & ~(cout_set & cout_data_reg[COUT_DONE_CLR]));
    end
  end

  assign done_seen = done_reg & ~chan_active_in;

  // ****************************************************************
  // Data channel handshake
  // ****************************************************************
  dshci_chan_e chan_state_reg;
  dshci_chan_e chan_state_next;

  always_comb begin
    chan_state_next = chan_state_reg;
    unique case (chan_state_reg)
      CHN_IDLE: begin
        if (init_accept) begin
          chan_state_next = CHN_REQ;
        end
      end
      CHN_REQ: begin
        if (!busy_reg) begin
          chan_state_next = CHN_IDLE;
        end else if (chan_grant_in && !chan_active_in) begin
          chan_state_next = CHN_SEND;
        end
      end
      CHN_SEND: chan_state_next = CHN_RUN;
      CHN_RUN: begin
        if (!busy_reg) begin
          chan_state_next = CHN_IDLE;
        end
      end
    endcase
    // A start in the cycle busy falls must still request
    if (init_accept) begin
      chan_state_next = CHN_REQ;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      chan_state_reg <= CHN_IDLE;
    end else begin
      chan_state_reg <= chan_state_next;
    end
  end

  // ****************************************************************
  // Control word store-back
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      chan_cw_store_out <= 1'b0;
      cw_comp_reg       <= 1'b0;
    end else begin
      chan_cw_store_out <= cout_set & cout_data_reg[COUT_CW_STORE];
      cw_comp_reg <= chan_cw_store_done_in |
                     (cw_comp_reg & ~(cout_set &
                                      cout_data_reg[COUT_CW_STORE]));
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      chan_request_out       <= 1'b0;
      chan_cw_addr_out       <= 9'h000;
      chan_cw_addr_valid_out <= 1'b0;
      chan_even_parity_out   <= 1'b0;
      start_search_out       <= 1'b0;
      terminate_out          <= 1'b0;
      busy_out               <= 1'b0;
    end else begin
      chan_request_out <= (chan_state_next == CHN_REQ);
      chan_cw_addr_valid_out <= (chan_state_next == CHN_SEND);
      chan_cw_addr_out <= {init_reg[INIT_CWA_LO:INIT_CWA_HI], 1'b0};
      chan_even_parity_out <= init_reg[INIT_EVEN_PAR] & ~chan_cw_cycle_in;
      start_search_out <= (chan_state_next == CHN_RUN) &&
                          (chan_state_reg == CHN_SEND);
      terminate_out <= cout_stop | (busy_reg & stop_event);
      busy_out      <= busy_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      disk_unit_out                   <= 2'h0;
      track_upper_out                 <= 1'b0;
      track_bcd_out                   <= 8'h00;
      segment_bcd_out                 <= 7'h00;
      parity_bias_out                 <= 6'h00;
      disk_parity_stop_disable_out    <= 1'b0;
      channel_parity_stop_disable_out <= 1'b0;
      write_mode_out                  <= 1'b0;
      sector_unit_select_out          <= SCSEL_RST;
    end else begin
      disk_unit_out   <= init_reg[INIT_DISK_LO:INIT_DISK_HI];
      track_upper_out <= init_reg[INIT_TRACK_HUND];
      track_bcd_out   <= init_reg[INIT_TRACK_LO:INIT_TRACK_HI];
      segment_bcd_out <= init_reg[INIT_SEG_LO:INIT_SEG_HI];
      parity_bias_out <= init_reg[INIT_BIAS_LO:INIT_BIAS_HI];
      disk_parity_stop_disable_out    <= init_reg[INIT_DPE_DIS];
      channel_parity_stop_disable_out <= init_reg[INIT_CPE_DIS];
      write_mode_out                  <= init_reg[INIT_WRITE];
      sector_unit_select_out          <= scsel_reg;
    end
  end

  // ****************************************************************
  // Read words and interrupt
  // ****************************************************************
  logic [0:35] word_in_value;
  logic [0:35] cond_in_value;

  always_comb begin
    word_in_value = DSHCI_WORD_RST;
    word_in_value[WIN_BIAS_LO:WIN_BIAS_HI]   =
      init_reg[INIT_BIAS_LO:INIT_BIAS_HI];
    word_in_value[WIN_SCSEL_LO:WIN_SCSEL_HI] = scsel_reg;
    word_in_value[WIN_SECT_LO:WIN_SECT_HI]   = sector_count_in;
  end

  always_comb begin
    cond_in_value = DSHCI_WORD_RST;
    cond_in_value[CIN_MAINT]     = sw_sync_reg[0];
    cond_in_value[CIN_PROT_MODE] = sw_sync_reg[1];
    cond_in_value[CIN_BOUNDS_LO:CIN_BOUNDS_HI] = sw_sync_reg[2:12];
    cond_in_value[CIN_XFER]      = transfer_in_progress_in;
    cond_in_value[CIN_SRCH_ERR]  = srch_err_reg;
    cond_in_value[CIN_FLAG_LO:CIN_FLAG_LO+9] = flag_q;
    cond_in_value[CIN_CW_COMP]   = cw_comp_reg;
    cond_in_value[CIN_BUSY]      = busy_reg;
    cond_in_value[CIN_DONE]      = done_seen;
    cond_in_value[CIN_PI_LO:CIN_PI_HI] = pi_level_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      read_data_out                <= DSHCI_WORD_RST;
      read_valid_out               <= 1'b0;
      interrupt_request_out        <= 1'b0;
      interrupt_priority_level_out <= PI_LEVEL_RST;
    end else begin
      read_valid_out <= word_in_transfer_in | conditions_in_transfer_in;
      if (word_in_transfer_in) begin
        read_data_out <= word_in_value;
      end else if (conditions_in_transfer_in) begin
        read_data_out <= cond_in_value;
      end
      interrupt_request_out        <= done_seen & (|pi_level_reg);
      interrupt_priority_level_out <= pi_level_reg;
    end
  end

endmodule

// ---- dv/dshci_chan_model.sv ----
// Behavioural data channel facing the synchronizer
`timescale 1ns/1ps
module dshci_chan_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  // Synchronizer side
  input  wire logic       slow_in,
  input  wire logic       request_in,
  input  wire logic [0:8] cw_addr_in,
  input  wire logic       cw_addr_valid_in,
  input  wire logic       cw_store_in,
  output logic            grant_out,
  output logic            active_out,
  output logic            cw_cycle_out,
  output logic            store_done_out
);
  logic [0:8] cwa_reg;
  logic [0:7] wc_reg;
  logic [0:1] wait_reg;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      {cwa_reg, wc_reg, wait_reg} <= 19'h00000;
      {grant_out, active_out, cw_cycle_out, store_done_out} <= 4'h0;
    end else begin
      wait_reg <= request_in ? wait_reg + 2'h1 : 2'h0;
      // Slow mode keeps the request queued for three cycles
      grant_out <= request_in && (!slow_in || wait_reg == 2'h3);
      store_done_out <= cw_store_in;
      cw_cycle_out <= cw_addr_valid_in;
      if (cw_addr_valid_in) begin
        cwa_reg <= cw_addr_in;
        // Control word list sits preloaded: four words
        wc_reg <= 8'hFC;
        active_out <= 1'h1;
      end else if (active_out) begin
        wc_reg <= wc_reg + 8'h01;
        active_out <= wc_reg != 8'hFF;
      end
    end
  end
endmodule

// ---- dv/dshci_assertions.sv ----
// Port-level checks on the disk synchronizer host interface
`timescale 1ns/1ps
module dshci_assertions (
  // Clock and reset
  input wire logic         clk_sys_in,
  input wire logic         reset_n_in,
  // Watched ports
  input wire logic         word_out_transfer_in,
  input wire logic         conditions_out_transfer_in,
  input wire logic [18:35] conditions_out_data_in,
  input wire logic         word_in_transfer_in,
  input wire logic         conditions_in_transfer_in,
  input wire logic [0:35]  read_data_out,
  input wire logic         read_valid_out,
  input wire logic         interrupt_request_out,
  input wire logic [0:2]   interrupt_priority_level_out,
  input wire logic         chan_request_out,
  input wire logic         chan_grant_in,
  input wire logic         chan_active_in,
  input wire logic         chan_cw_addr_valid_out,
  input wire logic         chan_cw_store_out,
  input wire logic         busy_out,
  input wire logic [0:7]   sector_count_in,
  input wire logic [0:5]   parity_bias_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // A strobe inside the three-cycle sequence is dropped, so skip it
  logic [0:1] co_seen_reg;
  wire        co_take = conditions_out_transfer_in && co_seen_reg == 2'h0;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) co_seen_reg <= 2'h0;
    else co_seen_reg <= {conditions_out_transfer_in, co_seen_reg[0]};
  end
  init_accept_a: assert property (
    word_out_transfer_in && !busy_out |=> busy_out && chan_request_out)
    else $error("initiation not accepted");
  busy_refuse_a: assert property (
    word_out_transfer_in && busy_out |-> ##2 $stable(parity_bias_out))
    else $error("refused initiation changed a field");
  grant_addr_a: assert property (
    chan_request_out && chan_grant_in && !chan_active_in |=>
    chan_cw_addr_valid_out && !chan_request_out)
    else $error("address not sent on grant");
  word_in_a: assert property (
    word_in_transfer_in |=> read_valid_out && read_data_out[0:17] == 18'h0
    && read_data_out[28:35] == $past(sector_count_in))
    else $error("word-in read wrong");
  cond_in_a: assert property (
    conditions_in_transfer_in && !word_in_transfer_in |=> read_valid_out
    && read_data_out[0:4] == 5'h00
    && !(read_data_out[32] && $past(chan_active_in)))
    else $error("conditions-in read wrong");
  irq_level_a: assert property (
    interrupt_request_out |-> interrupt_priority_level_out != 3'h0)
    else $error("interrupt at level zero");
  // Level register loads in the set phase, the port copy one edge later
  cout_level_a: assert property (
    co_take |-> ##4 interrupt_priority_level_out ==
    $past(conditions_out_data_in[33:35], 4))
    else $error("priority level not loaded");
  cw_store_a: assert property (
    co_take && conditions_out_data_in[30] |-> ##3 chan_cw_store_out)
    else $error("control word store not requested");
endmodule
bind dshci_top dshci_assertions i_dshci_assertions (
  .clk_sys_in, .reset_n_in, .word_out_transfer_in,
  .conditions_out_transfer_in, .conditions_out_data_in, .word_in_transfer_in,
  .conditions_in_transfer_in, .read_data_out, .read_valid_out,
  .interrupt_request_out, .interrupt_priority_level_out, .chan_request_out,
  .chan_grant_in, .chan_active_in, .chan_cw_addr_valid_out,
  .chan_cw_store_out, .busy_out, .sector_count_in, .parity_bias_out);

// ---- dv/test_disk_sync_host_control_interface.sv ----
// Self-checking bench for the disk synchronizer host interface
`timescale 1ns/1ps
module test_disk_sync_host_control_interface;
  typedef struct packed {logic [0:35] word; logic [0:8] addr;} dshci_row_s;
  // ****************************************************************
  // Signals, design and channel model
  // ****************************************************************
  logic         clk_sys_in = 1'h0;
  logic         reset_n_in = 1'h0;
  logic         wo_stb = 1'h0, co_stb = 1'h0, wi_stb = 1'h0, ci_stb = 1'h0;
  logic         op_end = 1'h0, slow = 1'h0, xfer = 1'h1, srch = 1'h0;
  logic [0:35]  wo_data = 36'h0;
  logic [18:35] co_data = 18'h0;
  logic [0:7]   sect = 8'h00;
  logic [0:9]   err_ev = 10'h000;
  logic [0:35]  rd;
  logic [0:8]   caddr;
  logic [0:7]   trk;
  logic [0:6]   seg;
  logic [0:5]   bias;
  logic [0:2]   pil;
  logic [0:1]   disk, scsel;
  logic         rv, irq, req, cav, cst, evp, tup, dpe, cpe, wr, busy;
  logic         grant, active, cw_done, cw_cyc, term, ss;
  int           num_errors = 0, n_checks = 0, k;
  dshci_row_s   rows [3] = '{'{36'hF33E6ABFF, 9'h1FE},
    '{36'h000000002, 9'h002}, '{36'h484D41500, 9'h100}};
  always #5 clk_sys_in = ~clk_sys_in;
  dshci_top i_dshci_top (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .word_out_transfer_in(wo_stb), .word_out_data_in(wo_data),
    .conditions_out_transfer_in(co_stb), .conditions_out_data_in(co_data),
    .word_in_transfer_in(wi_stb), .conditions_in_transfer_in(ci_stb),
    .read_data_out(rd), .read_valid_out(rv), .interrupt_request_out(irq),
    .interrupt_priority_level_out(pil), .chan_request_out(req),
    .chan_grant_in(grant), .chan_active_in(active),
    .chan_cw_addr_out(caddr), .chan_cw_addr_valid_out(cav),
    .chan_cw_store_out(cst), .chan_cw_store_done_in(cw_done),
    .chan_even_parity_out(evp), .chan_cw_cycle_in(cw_cyc),
    .disk_unit_out(disk), .track_upper_out(tup), .track_bcd_out(trk),
    .segment_bcd_out(seg), .parity_bias_out(bias),
    .disk_parity_stop_disable_out(dpe),
    .channel_parity_stop_disable_out(cpe), .write_mode_out(wr),
    .busy_out(busy), .start_search_out(ss), .terminate_out(term),
    .sector_unit_select_out(scsel), .sector_count_in(sect),
    .transfer_in_progress_in(xfer), .search_error_in(srch),
    .operation_end_in(op_end), .error_event_in(err_ev),
    .maintenance_area_only_in(1'h1), .protect_compare_mode_in(1'h0),
    .bounds_switch_value_in(11'h5A5));
  dshci_chan_model i_dshci_chan_model (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .request_in(req), .cw_addr_in(caddr), .cw_addr_valid_in(cav),
    .cw_store_in(cst), .grant_out(grant), .active_out(active),
    .cw_cycle_out(cw_cyc), .store_done_out(cw_done));
  // ****************************************************************
  // Tasks and sequence
  // ****************************************************************
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [0:35] got, input logic [0:35] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int n, input logic [0:35] d);
    wo_data = d;
    co_data = d[18:35];
    {wo_stb, co_stb, wi_stb, ci_stb, op_end} = 5'h10 >> n;
    @(negedge clk_sys_in);
    {wo_stb, co_stb, wi_stb, ci_stb, op_end} = 5'h00;
    // A read answer stands for this one cycle only
    if (n == 2 || n == 3) chk(rv, 1'h1);
    repeat (n == 1 ? 4 : n == 0 ? 1 : n / 2) @(negedge clk_sys_in);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys_in);
    reset_n_in = 1'h1;
    foreach (rows[i]) begin
      slow = i[0];
      sect = rows[i].word[27:34];
      pulse(0, rows[i].word);
      chk(busy, 1'h1);
      for (k = 0; k < 20 && cav !== 1'h1; k++) @(negedge clk_sys_in);
      if (k == 20) begin
        num_errors++;
        test_done();
      end
      chk(caddr, rows[i].addr);
      @(negedge clk_sys_in);
      chk(ss, 1'h1);
      chk({disk, tup, trk}, rows[i].word[0:10]);
      chk(seg, rows[i].word[11:17]);
      chk(bias, rows[i].word[18:23]);
      chk({dpe, cpe, wr}, rows[i].word[24:26]);
      @(negedge clk_sys_in);
      chk(evp, 1'h0);
      repeat (5) @(negedge clk_sys_in);
      chk(evp, rows[i].word[35]);
      pulse(2, 36'h0);
      chk(rd[0:25], {18'h0, rows[i].word[18:23], 2'h0});
      chk(rd[26:35], {2'h0, sect});
      pulse(4, 36'h0);
      chk({busy, irq}, 2'h0);
      $display("Test row %0d done", i);
    end
    pulse(0, rows[0].word);
    pulse(0, rows[2].word);
    repeat (8) @(negedge clk_sys_in);
    chk(bias, rows[0].word[18:23]);
    // Disk parity with its stop disabled must not terminate
    err_ev = 10'h020;
    @(negedge clk_sys_in);
    chk(term, 1'h0);
    err_ev = 10'h080;
    @(negedge clk_sys_in);
    chk(term, 1'h1);
    err_ev = 10'h000;
    pulse(3, 36'h0);
    chk({rd[22], rd[24]}, 2'h3);
    pulse(1, 36'h2FFFD);
    chk({busy, pil, scsel}, {1'h0, 3'h5, 2'h2});
    repeat (2) @(negedge clk_sys_in);
    pulse(3, 36'h0);
    chk(rd[0:17], {5'h00, 2'h2, 11'h5A5});
    chk(rd[18:31], {2'h2, 10'h000, 2'h2});
    $display("Test refusal and conditions done");
    pulse(0, rows[1].word);
    repeat (12) @(negedge clk_sys_in);
    pulse(4, 36'h0);
    repeat (2) @(negedge clk_sys_in);
    chk(irq, 1'h1);
    pulse(3, 36'h0);
    chk(rd[32], 1'h1);
    xfer = 1'h0;
    srch = 1'h1;
    @(negedge clk_sys_in);
    srch = 1'h0;
    pulse(3, 36'h0);
    chk(rd[18:19], 2'h1);
    pulse(1, 36'h0000D);
    chk(irq, 1'h0);
    reset_n_in = 1'h0;
    repeat (2) @(negedge clk_sys_in);
    chk({busy, irq, req, pil}, 6'h00);
    reset_n_in = 1'h1;
    pulse(0, rows[1].word);
    chk({busy, req}, 2'h3);
    $display("Test interrupt and reset done");
    test_done();
  end
endmodule
